//--- logic/indexed_stack_instruction_exec.sv
// Decode and execute for the move, push, pointer subtract and subtract-return instructions

module indexed_stack_instruction_exec (
	// Clock and reset
	input  wire logic                           i_mclk,
	input  wire logic                           i_rst,
	// Instruction word, one per instruction cycle
	input  wire logic                           i_instr_valid,
	input  wire logic [15:0]                    i_instr,
	// Data memory read data (same cycle as read address)
	input  wire logic [7:0]                     i_mem_rdata,
	// Return stack top
	input  wire logic [20:0]                    i_stack_top,
	// Data memory request
	output      stack_exec_pkg::mem_req_t       o_mem,
	// Pointer registers
	output      logic [11:0]                    o_ptr0,
	output      logic [11:0]                    o_ptr1,
	output      logic [11:0]                    o_ptr2,
	// Program counter load on return
	output      logic                           o_pc_load,
	output      logic [20:0]                    o_pc_value,
	// Word taken by this block
	output      logic                           o_busy
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Wraps modulo 4096; the data space has no bank bits here
	function automatic logic [11:0] index_addr(input logic [11:0] base, input logic [6:0] off);
		index_addr = base + {5'h00, off};
	endfunction

	// Move reads of this window yield 00h and move writes to it are dropped; pushes still write there
	function automatic logic is_indirect(input logic [11:0] a);
		is_indirect = (a >= stack_exec_pkg::INDIRECT_LO) && (a <= stack_exec_pkg::INDIRECT_HI);
	endfunction

	// Pointer minus a zero-extended 6-bit literal, wrapping in the 12-bit space
	function automatic logic [11:0] minus_lit(input logic [11:0] p, input logic [5:0] k);
		minus_lit = p - {6'h00, k};
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	stack_exec_pkg::state_t   state,      next_state;
	logic [11:0]              ptr0,       next_ptr0;
	logic [11:0]              ptr1,       next_ptr1;
	logic [11:0]              ptr2,       next_ptr2;
	logic [7:0]               held_data,  next_held_data;
	stack_exec_pkg::mem_req_t mem,        next_mem;
	logic                     pc_load,    next_pc_load;
	logic [20:0]              pc_value,   next_pc_value;
	logic                     busy,       next_busy;

	logic [3:0] w_hi;
	logic [3:0] w_op;
	logic [5:0] lit6;
	logic [1:0] sel;
	logic [11:0] src_addr;
	logic [11:0] dst_addr;

	assign w_hi     = i_instr[15:12];
	assign w_op     = i_instr[11:8];
	assign lit6     = i_instr[5:0];
	assign sel      = i_instr[stack_exec_pkg::SEL_LSB +: 2];
	// Both words carry their offset in the low seven bits, so one adder
	// serves the source address now and the destination address next cycle
	assign src_addr = index_addr(ptr2, i_instr[stack_exec_pkg::OFFSET_MSB:0]);
	assign dst_addr = src_addr;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	// Words outside these patterns pass by with no outputs while idle; the next valid word
	// after a move first word, and any word in the return dead cycle, is taken here whatever its opcode
	logic dec_ext;
	logic dec_move;
	logic dec_push;
	logic dec_sub;
	logic dec_return;
	logic dec_second;

	assign dec_ext    = i_instr_valid && (w_hi == stack_exec_pkg::EXT_HI);
	assign dec_move   = dec_ext && (w_op == stack_exec_pkg::OP_MOVE) &&
	                    (i_instr[stack_exec_pkg::MOVE_BIT] == stack_exec_pkg::MOVE_FIRST_BIT);
	assign dec_push   = dec_ext && (w_op == stack_exec_pkg::OP_PUSH);
	assign dec_sub    = dec_ext && (w_op == stack_exec_pkg::OP_SUBTRACT);
	assign dec_return = dec_sub && (sel == stack_exec_pkg::SEL_RETURN);
	assign dec_second = i_instr_valid && (w_hi == stack_exec_pkg::SECOND_WORD_HI);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_state     = state;
		next_ptr0      = ptr0;
		next_ptr1      = ptr1;
		next_ptr2      = ptr2;
		next_held_data = held_data;
		next_mem       = '0;
		next_pc_load   = 1'b0;
		next_pc_value  = pc_value;
		next_busy      = 1'b0;
		case (state)
			stack_exec_pkg::ST_IDLE: begin
				if (dec_ext) begin
					if (dec_move) begin
						// The memory answers in the cycle of the address, so the source
						// byte is caught now, before the second word moves the adder
						next_busy      = 1'b1;
						next_state     = stack_exec_pkg::ST_MOVE_DEST;
						next_held_data = is_indirect(src_addr) ?
						                 stack_exec_pkg::INDIRECT_DATA : i_mem_rdata;
						next_mem.rd    = 1'b1;
						next_mem.addr  = src_addr;
					end else if (dec_push) begin
						next_busy      = 1'b1;
						// Store at the old pointer, then step down: the stack grows toward 000h
						next_mem.wr    = 1'b1;
						next_mem.addr  = ptr2;
						next_mem.wdata = i_instr[7:0];
						next_ptr2      = ptr2 - stack_exec_pkg::PUSH_STEP;
					end else if (dec_sub) begin
						next_busy = 1'b1;
						// Flags are not touched here; this block owns none
						// Select 2 and 3 both act on pointer two; 3 also returns
						case (sel)
							2'h0: next_ptr0 = minus_lit(ptr0, lit6);
							2'h1: next_ptr1 = minus_lit(ptr1, lit6);
							default: begin
								next_ptr2 = minus_lit(ptr2, lit6);
							end
						endcase
						if (dec_return) begin
							next_pc_load  = 1'b1;
							next_pc_value = i_stack_top;
							next_state    = stack_exec_pkg::ST_RETURN_NOP;
						end
					end
				end
			end
			stack_exec_pkg::ST_MOVE_DEST: begin
				// Waits for the second word; the fetch stage supplies it next
				next_busy = 1'b1;
				if (i_instr_valid) begin
					next_state = stack_exec_pkg::ST_IDLE;
					// Any valid word closes the pair, so a stray word cannot hang the move;
					// program counter and stack top bytes are not guarded, code keeps clear
					if (dec_second &&
					    !is_indirect(dst_addr)) begin
						next_mem.wr    = 1'b1;
						next_mem.addr  = dst_addr;
						next_mem.wdata = held_data;
					end
				end
			end
			stack_exec_pkg::ST_RETURN_NOP: begin
				// Dead cycle while the return target is fetched
				// Words offered now are dropped; the core refetches from the target
				next_busy  = 1'b1;
				next_state = stack_exec_pkg::ST_IDLE;
			end
			default: begin
				next_state = stack_exec_pkg::ST_IDLE;
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	// Pointers start at zero, so a first push stores at 000h and wraps to FFFh
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			state     <= stack_exec_pkg::ST_IDLE;
			ptr0      <= stack_exec_pkg::PTR_RESET;
			ptr1      <= stack_exec_pkg::PTR_RESET;
			ptr2      <= stack_exec_pkg::PTR_RESET;
			held_data <= stack_exec_pkg::HELD_RESET;
			mem       <= '0;
			pc_load   <= 1'b0;
			pc_value  <= stack_exec_pkg::PC_RESET;
			busy      <= 1'b0;
		end else begin
			state     <= next_state;
			ptr0      <= next_ptr0;
			ptr1      <= next_ptr1;
			ptr2      <= next_ptr2;
			held_data <= next_held_data;
			mem       <= next_mem;
			pc_load   <= next_pc_load;
			pc_value  <= next_pc_value;
			busy      <= next_busy;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Plain copies of registers, so every output leaves a flip-flop
	assign o_mem      = mem;
	assign o_ptr0     = ptr0;
	assign o_ptr1     = ptr1;
	assign o_ptr2     = ptr2;
	assign o_pc_load  = pc_load;
	assign o_pc_value = pc_value;
	assign o_busy     = busy;

endmodule

//--- logic/stack_exec_pkg.sv
// Shared constants and carriers for the indexed stack instruction executor
package stack_exec_pkg;

	// ------------------------------------------------------------
	// Encodings
	// ------------------------------------------------------------
	localparam logic [3:0] EXT_HI          = 4'he;
	localparam logic [3:0] OP_SUBTRACT     = 4'h9;
	localparam logic [3:0] OP_PUSH         = 4'ha;
	localparam logic [3:0] OP_MOVE         = 4'hb;
	localparam logic       MOVE_FIRST_BIT  = 1'h1;
	localparam logic [3:0] SECOND_WORD_HI  = 4'hf;
	localparam logic [1:0] SEL_RETURN      = 2'h3;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int OFFSET_MSB  = 6;
	localparam int SEL_LSB     = 6;
	localparam int MOVE_BIT    = 7;

	// ------------------------------------------------------------
	// Address space and reset values
	// ------------------------------------------------------------
	localparam int         ADDR_W        = 12;
	localparam logic [7:0] INDIRECT_DATA = 8'h00;
	localparam logic [11:0] PTR_RESET    = 12'h000;
	localparam logic [7:0]  HELD_RESET   = 8'h00;
	localparam logic [20:0] PC_RESET     = 21'h000000;
	localparam logic [11:0] PUSH_STEP    = 12'h001;
	// Indirect addressing registers occupy this address window
	localparam logic [11:0] INDIRECT_LO  = 12'hfd9;
	localparam logic [11:0] INDIRECT_HI  = 12'hfef;

	typedef enum {ST_IDLE, ST_MOVE_DEST, ST_RETURN_NOP} state_t;

	// Data memory request carrier
	typedef struct packed {
		logic              rd;
		logic              wr;
		logic [ADDR_W-1:0] addr;
		logic [7:0]        wdata;
	} mem_req_t;

endpackage

//--- verif/stack_exec_properties.sv
// Port-level assertions for the indexed stack instruction executor
module stack_exec_properties (
	input wire logic                     i_mclk,
	input wire logic                     i_rst,
	input wire logic                     i_instr_valid,
	input wire logic [15:0]              i_instr,
	input wire logic [7:0]               i_mem_rdata,
	input wire logic [20:0]              i_stack_top,
	input wire stack_exec_pkg::mem_req_t o_mem,
	input wire logic [11:0]              o_ptr0,
	input wire logic [11:0]              o_ptr1,
	input wire logic [11:0]              o_ptr2,
	input wire logic                     o_pc_load,
	input wire logic [20:0]              o_pc_value,
	input wire logic                     o_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge i_mclk); endclocking
	default disable iff (i_rst);
	logic        take;
	logic        ind;
	logic        mv_wait;
	logic        dead;
	logic [11:0] dst;
	// Words are decoded only outside a pending move second word and the
	// return dead cycle; busy alone cannot tell, it also pulses after a push
	always_ff @(posedge i_mclk) begin
		if (i_rst) begin
			mv_wait <= 1'b0;
			dead    <= 1'b0;
		end else begin
			mv_wait <= mv_wait ? !i_instr_valid : take && i_instr[15:7] == 9'h1d7;
			dead    <= take && i_instr[15:6] == 10'h3a7;
		end
	end
	assign take = i_instr_valid && !mv_wait && !dead;
	assign dst = o_ptr2 + {5'h0, i_instr[6:0]};
	assign ind = dst >= stack_exec_pkg::INDIRECT_LO && dst <= stack_exec_pkg::INDIRECT_HI;
	sequence word1;
		take && i_instr[15:7] == 9'h1d7;
	endsequence
	sequence word2(bit w);
		i_instr_valid && i_instr[15:12] == 4'hf && ind == w;
	endsequence
	sequence sub(logic [1:0] f);
		take && i_instr[15:8] == 8'he9 && i_instr[7:6] == f;
	endsequence
	chk_push_store: assert property (
		take && i_instr[15:8] == 8'hea |=> o_mem.wr && o_mem.addr == $past(o_ptr2)
		&& o_mem.wdata == $past(i_instr[7:0]) && o_ptr2 == $past(o_ptr2) - 12'h001)
		else $error("push wrong");
	chk_move_read: assert property (word1 |=> o_mem.rd && o_mem.addr == $past(dst))
		else $error("move read wrong");
	chk_move_write: assert property (
		word1 ##1 word2(1'b0) |=> o_mem.wr && o_mem.addr == $past(dst))
		else $error("move write wrong");
	chk_src_zero: assert property (
		word1 ##0 ind ##1 word2(1'b0) |=> o_mem.wdata == 8'h00)
		else $error("indirect source not zero");
	chk_move_nop: assert property (word1 ##1 word2(1'b1) |=> !o_mem.wr)
		else $error("indirect dest written");
	chk_sub_ptr: assert property (
		sub(2'h0) |=> o_ptr0 == $past(o_ptr0) - {6'h0, $past(i_instr[5:0])} && $stable(o_ptr1))
		else $error("subtract wrong");
	chk_sub_return: assert property (
		sub(2'h3) |=> o_pc_load && o_pc_value == $past(i_stack_top)
		&& o_ptr2 == $past(o_ptr2) - {6'h0, $past(i_instr[5:0])})
		else $error("return wrong");
	chk_return_dead: assert property (
		sub(2'h3) |=> ##1 o_busy && !o_mem.wr && !o_pc_load && $stable(o_ptr2))
		else $error("dead cycle not idle");
endmodule

bind indexed_stack_instruction_exec stack_exec_properties i_stack_exec_properties (
	.i_mclk(i_mclk), .i_rst(i_rst),
	.i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_mem_rdata(i_mem_rdata),
	.i_stack_top(i_stack_top), .o_mem(o_mem), .o_ptr0(o_ptr0), .o_ptr1(o_ptr1),
	.o_ptr2(o_ptr2), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value), .o_busy(o_busy));

//--- verif/stack_mem_model.sv
// Data memory seen by the executor, read combinationally
module stack_mem_model (
	input  wire logic                     i_mclk,
	input  wire logic [15:0]              i_instr,
	input  wire logic [11:0]              i_ptr2,
	input  wire stack_exec_pkg::mem_req_t i_mem,
	output      logic [7:0]               o_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0]  mem [4096];
	logic [11:0] src;
	initial for (int i = 0; i < 4096; i++) mem[i] = 8'(i) ^ 8'ha5;
	assign src = i_ptr2 + {5'h0, i_instr[6:0]};
	// Inverted outside a move first word, so a late sample is caught
	assign o_rdata = i_instr[15:7] == 9'h1d7 ? mem[src] : ~mem[src];
	always @(posedge i_mclk) if (i_mem.wr) mem[i_mem.addr] <= i_mem.wdata;
endmodule

//--- verif/indexed_stack_instruction_exec_tb.sv
// Self-checking bench for the indexed stack instruction executor
module indexed_stack_instruction_exec_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic                     i_mclk = 0, i_rst = 1, i_instr_valid = 0, o_pc_load, o_busy;
	logic [15:0]              i_instr = 16'h0000;
	logic [20:0]              i_stack_top = 21'h1abcde;
	logic [20:0]              o_pc_value;
	logic [7:0]               i_mem_rdata;
	logic [11:0]              o_ptr0, o_ptr1, o_ptr2;
	stack_exec_pkg::mem_req_t o_mem;
	int                       miscompares = 0, checks = 0;
	always #5 i_mclk = ~i_mclk;
	indexed_stack_instruction_exec i_indexed_stack_instruction_exec (.i_mclk(i_mclk),
		.i_rst(i_rst), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
		.i_mem_rdata(i_mem_rdata), .i_stack_top(i_stack_top), .o_mem(o_mem), .o_ptr0(o_ptr0),
		.o_ptr1(o_ptr1), .o_ptr2(o_ptr2), .o_pc_load(o_pc_load), .o_pc_value(o_pc_value),
		.o_busy(o_busy));
	stack_mem_model i_stack_mem_model (.i_mclk(i_mclk), .i_instr(i_instr), .i_ptr2(o_ptr2),
		.i_mem(o_mem), .o_rdata(i_mem_rdata));
	task automatic cmp_bit(string name, logic exp, logic got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic cmp_byte(string name, logic [7:0] exp, logic [7:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic cmp_ptr(string name, logic [11:0] exp, logic [11:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic cmp_pc(string name, logic [20:0] exp, logic [20:0] got);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic issue(logic [15:0] w);
		i_instr_valid <= 1'h1;
		i_instr <= w;
		@(posedge i_mclk);
	endtask
	task automatic settle;
		i_instr_valid <= 1'h0;
		repeat (2) @(posedge i_mclk);
		#1;
	endtask
	task automatic summarize;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Two pushes from reset: the second lands after the pointer wrapped
	task automatic test_push;
		issue(16'hea5a);
		issue(16'heaff);
		settle;
		cmp_byte("mem000", 8'h5a, i_stack_mem_model.mem[0]);
		cmp_byte("memfff", 8'hff, i_stack_mem_model.mem[4095]);
		cmp_ptr("ptr2", 12'hffe, o_ptr2);
	endtask
	task automatic test_subtract;
		issue(16'he93f);
		issue(16'he941);
		issue(16'he990);
		settle;
		cmp_ptr("ptr0", 12'hfc1, o_ptr0);
		cmp_ptr("ptr1", 12'hfff, o_ptr1);
		cmp_ptr("ptr2", 12'hfee, o_ptr2);
	endtask
	// Destinations kept clear of program counter and stack top bytes
	task automatic test_move;
		issue(16'heb92);
		i_instr <= 16'hf893;
		#1;
		cmp_bit("mem_rd", 1'b1, o_mem.rd);
		cmp_ptr("rd_addr", 12'h000, o_mem.addr);
		@(posedge i_mclk);
		issue(16'heb80);
		issue(16'hf014);
		issue(16'heb92);
		issue(16'hf001);
		// A second word without the Fh prefix closes the move with no write
		issue(16'heb92);
		issue(16'h0895);
		settle;
		cmp_byte("mem001", 8'h5a, i_stack_mem_model.mem[1]);
		cmp_byte("mem002", 8'h00, i_stack_mem_model.mem[2]);
		cmp_byte("memfef", 8'h4a, i_stack_mem_model.mem[12'hfef]);
		cmp_byte("mem003", 8'ha6, i_stack_mem_model.mem[3]);
	endtask
	// A push offered in the dead cycle after the return must be ignored
	task automatic test_return;
		issue(16'he9c2);
		i_instr <= 16'hea33;
		#1;
		cmp_bit("pc_load", 1'b1, o_pc_load);
		cmp_pc("pc", 21'h1abcde, o_pc_value);
		cmp_ptr("ptr2", 12'hfec, o_ptr2);
		@(posedge i_mclk);
		i_instr_valid <= 1'h0;
		#1;
		cmp_bit("pc_load_end", 1'b0, o_pc_load);
		cmp_bit("busy_dead", 1'b1, o_busy);
		cmp_bit("wr_dead", 1'b0, o_mem.wr);
		@(posedge i_mclk);
		#1;
		cmp_bit("busy_end", 1'b0, o_busy);
		cmp_ptr("ptr2_end", 12'hfec, o_ptr2);
		cmp_byte("memfec", 8'h49, i_stack_mem_model.mem[12'hfec]);
	endtask
	initial begin
		repeat (6) @(posedge i_mclk);
		i_rst <= 1'h0;
		@(posedge i_mclk);
		test_push;
		@(posedge i_mclk);
		test_subtract;
		@(posedge i_mclk);
		test_move;
		@(posedge i_mclk);
		test_return;
		summarize;
	end
	initial begin
		repeat (500) @(posedge i_mclk);
		miscompares++;
		summarize;
	end
endmodule
